// ### logic/isol_cfg.svh
// Constants for the increment / skip / OR-literal execute slice.
// Assumes inclusion by bare name from logic/ sources.
`ifndef ISOL_CFG_SVH
`define ISOL_CFG_SVH
`define ISOL_OPC_INC_FILE 6'h0A
`define ISOL_OPC_INC_SKIP 6'h0F
`define ISOL_OPC_OR_LIT 6'h38
`define ISOL_OPC_LSB 8
`define ISOL_DEST_BIT 7
`define ISOL_ACCUM_RST 8'h00
`define ISOL_ZERO_RST 1'b0
`endif

// ### logic/isol_pkg.sv
// Types shared by the execute slice and its decoder.
// Assumes isol_cfg.svh constants are used alongside.
`default_nettype none
package isol_pkg;
  typedef enum logic [1:0] {
    ISOL_OP_NONE,
    ISOL_OP_INC_FILE,
    ISOL_OP_INC_SKIP,
    ISOL_OP_OR_LIT
  } isol_op_t;
  typedef struct packed {
    isol_op_t op;
    logic dest_file;
    logic [6:0] addr;
    logic [7:0] lit;
  } isol_dec_t;
  typedef struct packed {
    logic en;
    logic [6:0] addr;
    logic [7:0] data;
  } isol_wr_t;
endpackage
`default_nettype wire

// ### logic/isol_decode.sv
// Pure combinational decoder for three instruction words.
// Assumes a 14-bit instruction word from the fetch path.
`include "isol_cfg.svh"
`default_nettype none
module isol_decode (
  input wire logic [13:0] instr,
  output isol_pkg::isol_dec_t dec
);
  wire logic [5:0] opc = instr[13:`ISOL_OPC_LSB];
  wire logic is_inc = (opc == `ISOL_OPC_INC_FILE);
  wire logic is_skip = (opc == `ISOL_OPC_INC_SKIP);
  wire logic is_or = (opc == `ISOL_OPC_OR_LIT);
  isol_pkg::isol_op_t op_class;
  // Opcode class, other words fall through to none
  assign op_class = is_inc ? isol_pkg::ISOL_OP_INC_FILE :
                    is_skip ? isol_pkg::ISOL_OP_INC_SKIP :
                    is_or ? isol_pkg::ISOL_OP_OR_LIT :
                    isol_pkg::ISOL_OP_NONE;
  // One driver for the whole word keeps the output a single variable
  assign dec = {op_class, instr[`ISOL_DEST_BIT], instr[6:0], instr[7:0]};
endmodule
`default_nettype wire

// ### logic/isol_core.sv
// Contract
// - Increment opcode adds one to file register
// - Dest bit 0 to accumulator, 1 to file
// - Increment wraps at 256, sets zero flag
// - Skip opcode increments and tests for zero
// - Zero result discards prefetched word as no-op
// - Increment-and-skip leaves status flags unchanged
// - OR-literal ORs literal into accumulator
// - OR-literal updates zero flag only
//
// Execute slice for increment, increment-skip and OR-literal.
// Assumes the register file returns file_rdata combinationally for
// the address of the current word, and that the fetch path presents
// the prefetched word on instr with instr_valid each cycle.
`include "isol_cfg.svh"
`default_nettype none
module isol_core (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [13:0] instr,
  input wire logic instr_valid,
  input wire logic [7:0] file_rdata,
  output logic [6:0] file_raddr,
  output isol_pkg::isol_wr_t file_wr,
  output logic [7:0] accum,
  output logic zero_flag,
  output logic skip_busy,
  output logic done
);
  isol_pkg::isol_dec_t dec;

  isol_decode i_isol_decode (
    .instr(instr),
    .dec(dec)
  );

  function automatic logic [7:0] isol_inc8(input logic [7:0] v);
    isol_inc8 = 8'(v + 8'h01);
  endfunction

  // Word in the skip slot is squashed: executes as a no-op
  wire logic live = instr_valid && !skip_busy;
  wire logic do_inc = live && (dec.op == isol_pkg::ISOL_OP_INC_FILE);
  wire logic do_skip = live && (dec.op == isol_pkg::ISOL_OP_INC_SKIP);
  wire logic do_or = live && (dec.op == isol_pkg::ISOL_OP_OR_LIT);
  wire logic [7:0] inc_res = isol_inc8(file_rdata);
  wire logic [7:0] or_res = accum | dec.lit;
  wire logic any_inc = do_inc || do_skip;
  wire logic to_file = any_inc && dec.dest_file;
  wire logic to_acc = any_inc && !dec.dest_file;

  // Next values; the skip word keeps the flag untouched
  wire logic [7:0] next_accum = to_acc ? inc_res :
                                do_or ? or_res : accum;
  wire logic next_zero_flag = do_inc ? (inc_res == 8'h00) :
                              do_or ? (or_res == 8'h00) :
                              zero_flag;
  wire logic next_skip = do_skip && (inc_res == 8'h00);
  wire logic next_done = do_inc || do_or || (do_skip && !next_skip);

  assign file_raddr = dec.addr;

  // Architectural state; one word retires per cycle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      accum <= `ISOL_ACCUM_RST;
      zero_flag <= `ISOL_ZERO_RST;
      skip_busy <= 1'b0;
      done <= 1'b0;
    end else begin
      accum <= next_accum;
      zero_flag <= next_zero_flag;
      skip_busy <= next_skip;
      done <= next_done;
    end
  end

  // Registered write port so the output is a flop
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      file_wr <= '0;
    end else begin
      file_wr.en <= to_file;
      file_wr.addr <= dec.addr;
      file_wr.data <= inc_res;
    end
  end

  // Z after a plain increment is set only by the wrap to zero
  property p_inc_zero;
    @(posedge core_clk) disable iff (!rst_b)
      do_inc |=> (zero_flag == ($past(file_rdata) == 8'hFF));
  endproperty
  a_inc_zero: assert property (p_inc_zero)
    else $error("increment zero flag wrong");

  // With d clear the sum lands in the accumulator
  property p_inc_acc;
    @(posedge core_clk) disable iff (!rst_b)
      (do_inc && !dec.dest_file) |=> accum == 8'($past(file_rdata) + 8'h01);
  endproperty
  a_inc_acc: assert property (p_inc_acc)
    else $error("increment to accumulator wrong");

  // With d set the sum goes back to the file, accumulator kept
  property p_inc_file;
    @(posedge core_clk) disable iff (!rst_b)
      (any_inc && dec.dest_file) |=> file_wr.en &&
        file_wr.data == 8'($past(file_rdata) + 8'h01) &&
        accum == $past(accum);
  endproperty
  a_inc_file: assert property (p_inc_file)
    else $error("increment to file wrong");

  // For a plain increment with d set the flag follows the value written back
  property p_inc_file_zero;
    @(posedge core_clk) disable iff (!rst_b)
      (do_inc && dec.dest_file) |=> zero_flag == (file_wr.data == 8'h00);
  endproperty
  a_inc_file_zero: assert property (p_inc_file_zero)
    else $error("increment to file zero flag wrong");

  // Skip into the accumulator leaves the file alone
  property p_skip_acc;
    @(posedge core_clk) disable iff (!rst_b)
      (do_skip && !dec.dest_file) |=>
        accum == 8'($past(file_rdata) + 8'h01) && !file_wr.en;
  endproperty
  a_skip_acc: assert property (p_skip_acc)
    else $error("skip to accumulator wrong");

  // Skip decision follows the incremented value only
  property p_skip_test;
    @(posedge core_clk) disable iff (!rst_b)
      do_skip |=> skip_busy == ($past(file_rdata) == 8'hFF);
  endproperty
  a_skip_test: assert property (p_skip_test)
    else $error("skip decision wrong");

  // The flag is never touched by the skip op
  property p_skip_flag;
    @(posedge core_clk) disable iff (!rst_b)
      do_skip |=> $stable(zero_flag);
  endproperty
  a_skip_flag: assert property (p_skip_flag)
    else $error("skip changed zero flag");

  // The skip's own write may land; the squashed word leaves no trace
  property p_skip_squash;
    @(posedge core_clk) disable iff (!rst_b)
      (do_skip && file_rdata == 8'hFF) |=> skip_busy ##1
        (!skip_busy && !file_wr.en && !done &&
        $stable(accum) && $stable(zero_flag));
  endproperty
  a_skip_squash: assert property (p_skip_squash)
    else $error("skipped word not squashed");

  // A non-zero skip retires like any one-cycle op
  property p_skip_noskip;
    @(posedge core_clk) disable iff (!rst_b)
      (do_skip && file_rdata != 8'hFF) |=> !skip_busy && done;
  endproperty
  a_skip_noskip: assert property (p_skip_noskip)
    else $error("non-zero skip not one cycle");

  // Single-cycle ops retire at once and never start a skip
  property p_one_cycle;
    @(posedge core_clk) disable iff (!rst_b)
      (do_inc || do_or) |=> done && !skip_busy;
  endproperty
  a_one_cycle: assert property (p_one_cycle)
    else $error("single-cycle op did not retire");

  // Idle, unknown or squashed words must leave no trace
  property p_quiet;
    @(posedge core_clk) disable iff (!rst_b)
      (!live || dec.op == isol_pkg::ISOL_OP_NONE) |=> !done &&
        !file_wr.en && !skip_busy && $stable(accum) && $stable(zero_flag);
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("idle or squashed word had an effect");

  // OR result goes to the accumulator only
  property p_or_acc;
    @(posedge core_clk) disable iff (!rst_b)
      do_or |=> accum == ($past(accum) | $past(dec.lit)) && !file_wr.en;
  endproperty
  a_or_acc: assert property (p_or_acc)
    else $error("or literal result wrong");

  // Flag tracks the OR result
  property p_or_zero;
    @(posedge core_clk) disable iff (!rst_b)
      do_or |=> zero_flag == (accum == 8'h00);
  endproperty
  a_or_zero: assert property (p_or_zero)
    else $error("or literal zero flag wrong");

  // Decoder class for the plain increment
  property p_dec_inc;
    @(posedge core_clk) disable iff (!rst_b)
      (live && instr[13:`ISOL_OPC_LSB] == `ISOL_OPC_INC_FILE) |->
        dec.op == isol_pkg::ISOL_OP_INC_FILE;
  endproperty
  a_dec_inc: assert property (p_dec_inc)
    else $error("increment opcode not decoded");

  // Decoder class for increment-and-skip
  property p_dec_skip;
    @(posedge core_clk) disable iff (!rst_b)
      (live && instr[13:`ISOL_OPC_LSB] == `ISOL_OPC_INC_SKIP) |->
        dec.op == isol_pkg::ISOL_OP_INC_SKIP;
  endproperty
  a_dec_skip: assert property (p_dec_skip)
    else $error("skip opcode not decoded");

  // Decoder class for the OR literal
  property p_dec_or;
    @(posedge core_clk) disable iff (!rst_b)
      (live && instr[13:`ISOL_OPC_LSB] == `ISOL_OPC_OR_LIT) |->
        dec.op == isol_pkg::ISOL_OP_OR_LIT;
  endproperty
  a_dec_or: assert property (p_dec_or)
    else $error("or literal opcode not decoded");
endmodule
`default_nettype wire

// ### tb/isol_regfile_model.sv
// Register file partner: 128 bytes, combinational read.
// Assumes writes arrive as one-cycle pulses on file_wr.en.
`default_nettype none
module isol_regfile_model (
  input wire logic core_clk,
  input wire logic [6:0] file_raddr,
  input wire isol_pkg::isol_wr_t file_wr,
  output logic [7:0] file_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [128];
  // Seed pattern puts 8'hFF at address 7'h0F
  initial for (int i = 0; i < 128; i++) mem[i] = 8'hF0 + i[7:0];
  assign file_rdata = mem[file_raddr];
  // No bypass: a write is seen from the next cycle on
  always @(posedge core_clk) if (file_wr.en) mem[file_wr.addr] <= file_wr.data;
endmodule
`default_nettype wire

// ### tb/test_isol_core.sv
// Directed bench for the increment, skip and OR-literal slice.
// Assumes the register file model and one word per issued cycle.
`default_nettype none
module test_isol_core;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic instr_valid = 1'b0;
  logic [13:0] instr = 14'h0000;
  logic [7:0] file_rdata, accum;
  logic [6:0] file_raddr;
  isol_pkg::isol_wr_t file_wr;
  logic zero_flag, skip_busy, done;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  isol_core i_isol_core (.core_clk(core_clk), .rst_b(rst_b), .instr(instr),
    .instr_valid(instr_valid), .file_rdata(file_rdata),
    .file_raddr(file_raddr), .file_wr(file_wr), .accum(accum),
    .zero_flag(zero_flag), .skip_busy(skip_busy), .done(done));
  isol_regfile_model i_isol_regfile_model (.core_clk(core_clk),
    .file_raddr(file_raddr), .file_wr(file_wr), .file_rdata(file_rdata));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  // Hang guard, far above the few dozen cycles needed
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 400) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic drive(input logic [13:0] w, input logic v);
    @(posedge core_clk);
    #1;
    instr = w;
    instr_valid = v;
  endtask
  // One word, then an idle cycle; returns with its results settled
  task automatic run(input logic [13:0] w);
    drive(w, 1'b1);
    drive(14'h0000, 1'b0);
  endtask
  task automatic chk(input string n, input logic [15:0] e, g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic t_inc;
    run(14'h0A0F);
    chk("accum", 16'h0000, accum);
    chk("zero", 16'h0001, zero_flag);
    chk("done", 16'h0001, done);
    chk("wr_en", 16'h0000, file_wr.en);
    run(14'h0A85);
    chk("wr", {1'b1, 7'h05, 8'hF6}, file_wr);
    chk("zero", 16'h0000, zero_flag);
    chk("accum", 16'h0000, accum);
    $display("test inc done");
  endtask
  // Ends with an undecoded word, which must change nothing
  task automatic t_or;
    run(14'h3800);
    chk("zero", 16'h0001, zero_flag);
    run(14'h3835);
    chk("accum", 16'h0035, accum);
    chk("zero", 16'h0000, zero_flag);
    chk("done", 16'h0001, done);
    run(14'h38CA);
    chk("accum", 16'h00FF, accum);
    run(14'h3000);
    chk("accum", 16'h00FF, accum);
    chk("done", 16'h0000, done);
    $display("test or done");
  endtask
  // Skip taken squashes the word presented right behind it
  task automatic t_skip;
    drive(14'h0F0F, 1'b1);
    drive(14'h3801, 1'b1);
    chk("accum", 16'h0000, accum);
    chk("skip", 16'h0001, skip_busy);
    chk("done", 16'h0000, done);
    chk("zero", 16'h0000, zero_flag);
    drive(14'h0000, 1'b0);
    chk("skip", 16'h0000, skip_busy);
    chk("accum", 16'h0000, accum);
    chk("done", 16'h0000, done);
    run(14'h3800);
    run(14'h0F85);
    chk("wr", {1'b1, 7'h05, 8'hF7}, file_wr);
    chk("zero", 16'h0001, zero_flag);
    chk("skip", 16'h0000, skip_busy);
    chk("done", 16'h0001, done);
    // Skip back into the file; the squashed file write must not land
    drive(14'h0F8F, 1'b1);
    drive(14'h0A85, 1'b1);
    chk("wr", {1'b1, 7'h0F, 8'h00}, file_wr);
    chk("skip", 16'h0001, skip_busy);
    drive(14'h0000, 1'b0);
    chk("wr_en", 16'h0000, file_wr.en);
    chk("done", 16'h0000, done);
    chk("zero", 16'h0001, zero_flag);
    $display("test skip done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    chk("rst_accum", 16'h0000, accum);
    t_inc();
    t_or();
    t_skip();
    wrap_up();
  end
endmodule
`default_nettype wire
